// ---- core/rbmc_pkg.sv ----
// Package for the robot behaviour and mode controller.
package rbmc_pkg;
    // Timing: debounce hold and beacon period, in ns, with cycle counts at 8 ns.
    localparam int CLK_NS          = 8;
    localparam int DEBOUNCE_NS     = 80;
    localparam int DEBOUNCE_CYC    = (DEBOUNCE_NS + CLK_NS - 1) / CLK_NS;
    localparam int BEACON_NS       = 800;
    localparam int BEACON_CYC      = BEACON_NS / CLK_NS;
    localparam int BACKUP_CYC      = 16;
    localparam int TURN45_CYC      = 8;
    localparam int LED_PAT_BITS    = 4;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;

    // Motor commands.
    typedef enum logic [2:0]
    {
        RBMC_MOT_STOP  = 3'h0,
        RBMC_MOT_FWD   = 3'h1,
        RBMC_MOT_REV   = 3'h2,
        RBMC_MOT_LEFT  = 3'h3,
        RBMC_MOT_RIGHT = 3'h4
    } rbmc_motor_e;

    // Top-level modes, Gray coded along sleep, active, hibernate.
    typedef enum logic [1:0]
    {
        RBMC_SLEEP = 2'h0,
        RBMC_ACTIVE = 2'h1,
        RBMC_HIBER = 2'h3,
        RBMC_OFF   = 2'h2
    } rbmc_mode_e;

    // Active behaviours.
    typedef enum logic [1:0]
    {
        RBMC_WALK   = 2'h0,
        RBMC_FORAGE = 2'h1,
        RBMC_BEACON = 2'h3,
        RBMC_CONV   = 2'h2
    } rbmc_beh_e;

    // Contact and button inputs travel together.
    typedef struct packed
    {
        logic feel_left;
        logic feel_right;
        logic halt_btn;
        logic power_btn;
    } rbmc_touch_s;

    // Dual colour LED drive.
    typedef struct packed
    {
        logic red;
        logic green;
    } rbmc_led_s;
endpackage

// ---- core/rbmc_ctrl.sv ----
// Mode, behaviour, avoidance and LED control for the solar robot.
`timescale 1ns/1ns
// What this block does
// - Starts asleep; leaves sleep for active mode only when light is sufficient.
// - Low light in active mode returns cleanly to sleep.
// - Random walk: forward random distance, then random turn, repeatedly.
// - On contact: reverse fixed distance at once, then turn 45 degrees away.
// - One feeler closed: turn toward the opposite side.
// - Both feelers together: turn direction chosen at random.
// - Light below continuous level during walk switches to forage.
// - Forage continues until light acceptable or energy source found.
// - Very bright area: stop, beacon light level for set period, resume foraging.
// - Beacon received while foraging enters convergence.
// - Convergence lasts while light rises or beacons arrive.
// - Halt press in active mode hibernates with all motion stopped.
// - Second halt press restores the previous behaviour.
// - Power button hard-off never returns to active by itself.
// - Weak solar current: low-power state, motors and sensors off.
// - Soft power-off resumes itself on suitable sensor input.
// - LED colour differs per mode.
// - LED pulse pattern unique per behaviour.
module rbmc_ctrl
    import rbmc_pkg::*;
#(
    parameter int LW = 8
)
(
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire rbmc_touch_s      touch_in,
    input  wire logic [LW-1:0]    light_level,
    input  wire logic [LW-1:0]    wake_level,
    input  wire logic [LW-1:0]    forage_level,
    input  wire logic [LW-1:0]    bright_level,
    input  wire logic             beacon_rx,
    output rbmc_motor_e           motor_cmd,
    output logic                  sensors_on,
    output logic                  standby,
    output logic                  ir_tx_en,
    output logic [LW-1:0]         ir_tx_data,
    output rbmc_led_s             led
);

    // Two-flop synchronisers for pins.
    rbmc_touch_s touch_meta_reg;
    rbmc_touch_s touch_sync_reg;
    logic        beacon_meta_reg;
    logic        beacon_sync_reg;
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            touch_meta_reg  <= '0;
            touch_sync_reg  <= '0;
            beacon_meta_reg <= 1'b0;
            beacon_sync_reg <= 1'b0;
        end
        else
        begin
            touch_meta_reg  <= touch_in;
            touch_sync_reg  <= touch_meta_reg;
            beacon_meta_reg <= beacon_rx;
            beacon_sync_reg <= beacon_meta_reg;
        end
    end

    // Debounce: a level is accepted after it holds steady for the debounce count.
    localparam int DBW = $clog2(DEBOUNCE_CYC + 1);
    logic [3:0]     stable_reg;
    logic [3:0]     stable_prev_reg;
    logic [DBW-1:0] db_cnt_reg [4];
    logic [3:0]     press_evt;
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            stable_reg      <= 4'h0;
            stable_prev_reg <= 4'h0;
            for (int i = 0; i < 4; i++)
                db_cnt_reg[i] <= '0;
        end
        else
        begin
            stable_prev_reg <= stable_reg;
            for (int i = 0; i < 4; i++)
            begin
                if (touch_sync_reg[i] == stable_reg[i])
                    db_cnt_reg[i] <= '0;
                else if (db_cnt_reg[i] == DBW'(DEBOUNCE_CYC - 1))
                begin
                    stable_reg[i] <= touch_sync_reg[i];
                    db_cnt_reg[i] <= '0;
                end
                else
                    db_cnt_reg[i] <= db_cnt_reg[i] + 1'b1;
            end
        end
    end
    // One event per rising debounced edge; bit order follows the struct.
    assign press_evt = stable_reg & ~stable_prev_reg;
    wire evt_left  = press_evt[3];
    wire evt_right = press_evt[2];
    wire evt_halt  = press_evt[1];
    wire evt_power = press_evt[0];

    // Random source shared by walk distances, turns and tie-breaks.
    logic [15:0] lfsr_reg;
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            lfsr_reg <= LFSR_SEED;
        else
            lfsr_reg <= {lfsr_reg[14:0],
                         lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    end

    // Mode machine.
    rbmc_mode_e mode_reg;
    rbmc_beh_e  beh_reg;
    wire light_ok  = light_level >= wake_level;
    wire light_low = light_level < forage_level;
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            mode_reg <= RBMC_SLEEP;
        else
        begin
            case (mode_reg)
                RBMC_SLEEP:
                    if (evt_power)
                        mode_reg <= RBMC_OFF;
                    else if (light_ok)
                        mode_reg <= RBMC_ACTIVE;
                RBMC_ACTIVE:
                    if (evt_power)
                        mode_reg <= RBMC_OFF;
                    else if (evt_halt)
                        mode_reg <= RBMC_HIBER;
                    else if (light_level < (wake_level >> 1))
                        mode_reg <= RBMC_SLEEP;
                RBMC_HIBER:
                    if (evt_power)
                        mode_reg <= RBMC_OFF;
                    else if (evt_halt)
                        mode_reg <= RBMC_ACTIVE;
                RBMC_OFF:
                    mode_reg <= RBMC_OFF;
                default:
                    mode_reg <= RBMC_SLEEP;
            endcase
        end
    end

    // Avoidance manoeuvre state: reverse then turn, overriding behaviour motion.
    logic       avoid_reg;
    logic       avoid_turn_reg;
    logic       avoid_right_reg;
    logic [7:0] avoid_cnt_reg;
    wire        moving = (mode_reg == RBMC_ACTIVE) && (beh_reg != RBMC_BEACON);
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            avoid_reg       <= 1'b0;
            avoid_turn_reg  <= 1'b0;
            avoid_right_reg <= 1'b0;
            avoid_cnt_reg   <= 8'h00;
        end
        else if (mode_reg != RBMC_ACTIVE)
            avoid_reg <= 1'b0;
        else if (!avoid_reg && moving && (evt_left || evt_right))
        begin
            avoid_reg      <= 1'b1;
            avoid_turn_reg <= 1'b0;
            avoid_cnt_reg  <= 8'(BACKUP_CYC - 1);
            if (evt_left && evt_right)
                avoid_right_reg <= lfsr_reg[0];
            else
                avoid_right_reg <= evt_left;
        end
        else if (avoid_reg)
        begin
            if (avoid_cnt_reg != 8'h00)
                avoid_cnt_reg <= avoid_cnt_reg - 8'h01;
            else if (!avoid_turn_reg)
            begin
                avoid_turn_reg <= 1'b1;
                avoid_cnt_reg  <= 8'(TURN45_CYC - 1);
            end
            else
                avoid_reg <= 1'b0;
        end
    end

    // Behaviour machine, held while hibernating so the halt release restores it.
    logic [LW-1:0] prev_light_reg;
    logic [7:0]    beacon_cnt_reg;
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            beh_reg        <= RBMC_WALK;
            prev_light_reg <= '0;
            beacon_cnt_reg <= 8'h00;
        end
        else if (mode_reg == RBMC_SLEEP)
            beh_reg <= RBMC_WALK;
        else if (mode_reg == RBMC_ACTIVE && !avoid_reg)
        begin
            prev_light_reg <= light_level;
            case (beh_reg)
                RBMC_WALK:
                    if (light_low)
                        beh_reg <= RBMC_FORAGE;
                RBMC_FORAGE:
                    if (light_level >= bright_level)
                    begin
                        beh_reg        <= RBMC_BEACON;
                        beacon_cnt_reg <= 8'(BEACON_CYC - 1);
                    end
                    else if (beacon_sync_reg)
                        beh_reg <= RBMC_CONV;
                    else if (!light_low)
                        beh_reg <= RBMC_WALK;
                RBMC_BEACON:
                    if (beacon_cnt_reg != 8'h00)
                        beacon_cnt_reg <= beacon_cnt_reg - 8'h01;
                    else
                        beh_reg <= RBMC_FORAGE;
                RBMC_CONV:
                    if (!beacon_sync_reg && light_level <= prev_light_reg)
                        beh_reg <= RBMC_FORAGE;
                default:
                    beh_reg <= RBMC_WALK;
            endcase
        end
    end

    // Walk step generator: random forward run, then random turn held to one side.
    logic       step_turn_reg;
    logic       step_right_reg;
    logic [5:0] step_cnt_reg;
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            step_turn_reg  <= 1'b0;
            step_right_reg <= 1'b0;
            step_cnt_reg   <= 6'h00;
        end
        else if (mode_reg == RBMC_ACTIVE && !avoid_reg)
        begin
            if (step_cnt_reg != 6'h00)
                step_cnt_reg <= step_cnt_reg - 6'h01;
            else
            begin
                step_turn_reg  <= !step_turn_reg;
                step_right_reg <= lfsr_reg[7];
                step_cnt_reg   <= lfsr_reg[5:0] | 6'h01;
            end
        end
    end

    // Motion, power and beacon outputs.
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            motor_cmd  <= RBMC_MOT_STOP;
            sensors_on <= 1'b0;
            standby    <= 1'b1;
            ir_tx_en   <= 1'b0;
            ir_tx_data <= '0;
        end
        else
        begin
            sensors_on <= (mode_reg == RBMC_ACTIVE) || (mode_reg == RBMC_HIBER);
            standby    <= (mode_reg == RBMC_SLEEP) || (mode_reg == RBMC_OFF);
            ir_tx_en   <= (mode_reg == RBMC_ACTIVE) && (beh_reg == RBMC_BEACON);
            ir_tx_data <= light_level;
            if (mode_reg != RBMC_ACTIVE)
                motor_cmd <= RBMC_MOT_STOP;
            else if (avoid_reg)
                motor_cmd <= !avoid_turn_reg ? RBMC_MOT_REV
                           : (avoid_right_reg ? RBMC_MOT_RIGHT : RBMC_MOT_LEFT);
            else if (beh_reg == RBMC_BEACON)
                motor_cmd <= RBMC_MOT_STOP;
            else if (beh_reg == RBMC_WALK && step_turn_reg)
                motor_cmd <= step_right_reg ? RBMC_MOT_RIGHT : RBMC_MOT_LEFT;
            else
                motor_cmd <= RBMC_MOT_FWD;
        end
    end

    // LED: colour per mode, pulse pattern per behaviour.
    logic [LED_PAT_BITS+1:0] led_phase_reg;
    logic [3:0]              pat;
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            led_phase_reg <= '0;
        else
            led_phase_reg <= led_phase_reg + 1'b1;
    end
    always_comb
    begin
        case (beh_reg)
            RBMC_WALK:   pat = 4'h7;
            RBMC_FORAGE: pat = 4'h5;
            RBMC_BEACON: pat = 4'h1;
            RBMC_CONV:   pat = 4'h3;
            default:     pat = 4'h0;
        endcase
    end
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            led <= '0;
        else
        begin
            case (mode_reg)
                RBMC_ACTIVE: led <= '{red: 1'b0, green: pat[led_phase_reg[LED_PAT_BITS+1:2]
                                      % 4]};
                RBMC_HIBER:  led <= '{red: pat[led_phase_reg[LED_PAT_BITS+1:2] % 4],
                                      green: 1'b0};
                RBMC_SLEEP:  led <= '{red: 1'b1, green: 1'b1};
                default:     led <= '{red: 1'b0, green: 1'b0};
            endcase
        end
    end

    // Assertions.
    sequence halt_seq;
        mode_reg == RBMC_ACTIVE && evt_halt && !evt_power;
    endsequence
    hibernate_entry_a: assert property (@(posedge sys_clk) disable iff (reset)
        halt_seq |=> mode_reg == RBMC_HIBER) else $error("halt not hibernating");
    hibernate_stop_a: assert property (@(posedge sys_clk) disable iff (reset)
        mode_reg == RBMC_HIBER |=> motor_cmd == RBMC_MOT_STOP) else $error("motion in hibernate");
    resume_beh_a: assert property (@(posedge sys_clk) disable iff (reset)
        mode_reg == RBMC_HIBER |=> $stable(beh_reg)) else $error("behaviour lost");
    hard_off_a: assert property (@(posedge sys_clk) disable iff (reset)
        mode_reg == RBMC_OFF |=> mode_reg == RBMC_OFF) else $error("left hard off");
    wake_light_a: assert property (@(posedge sys_clk) disable iff (reset)
        mode_reg == RBMC_SLEEP && !evt_power && light_ok |=> mode_reg == RBMC_ACTIVE)
        else $error("no wake");
    avoid_rev_a: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(avoid_reg) && mode_reg == RBMC_ACTIVE |=> motor_cmd == RBMC_MOT_REV)
        else $error("no reverse");
    turn_side_a: assert property (@(posedge sys_clk) disable iff (reset)
        !avoid_reg && moving && evt_left && !evt_right |=> avoid_right_reg)
        else $error("wrong turn side");
    beacon_tx_a: assert property (@(posedge sys_clk) disable iff (reset)
        mode_reg == RBMC_ACTIVE && beh_reg == RBMC_BEACON |=> ir_tx_en)
        else $error("beacon silent");
    forage_entry_a: assert property (@(posedge sys_clk) disable iff (reset)
        mode_reg == RBMC_ACTIVE && !avoid_reg && beh_reg == RBMC_WALK && light_low
        |=> beh_reg == RBMC_FORAGE || mode_reg != RBMC_ACTIVE) else $error("no forage");
    conv_entry_a: assert property (@(posedge sys_clk) disable iff (reset)
        mode_reg == RBMC_ACTIVE && !avoid_reg && beh_reg == RBMC_FORAGE && beacon_sync_reg
        && light_level < bright_level |=> beh_reg == RBMC_CONV) else $error("no converge");
    conv_exit_a: assert property (@(posedge sys_clk) disable iff (reset)
        mode_reg == RBMC_ACTIVE && !avoid_reg && beh_reg == RBMC_CONV && !beacon_sync_reg
        && light_level <= prev_light_reg |=> beh_reg == RBMC_FORAGE) else $error("conv stuck");
endmodule

// ---- tb/rbmc_world.sv ----
// Model of the feelers and buttons, which chatter on every press and release.
`timescale 1ns/1ns
module rbmc_world
    import rbmc_pkg::*;
(
    input  wire logic   sys_clk,
    output rbmc_touch_s touch
);
    // Open switches read low while nothing touches them.
    initial
    begin
        touch = '0;
    end

    // Closes the contacts with chatter, holds them, then opens them with chatter.
    task automatic press(input logic [3:0] which, input int hold);
        for (int n = 0; n < 10; n++)
        begin
            @(posedge sys_clk);
            #1 touch = n[0] ? rbmc_touch_s'(4'h0) : rbmc_touch_s'(which);
            if (n == 4)
                repeat (hold) @(posedge sys_clk);
        end
    endtask
endmodule

// ---- tb/rbmc_ctrl_tb_top.sv ----
// Self-checking bench for the robot mode and behaviour controller.
`timescale 1ns/1ns
module rbmc_ctrl_tb_top
    import rbmc_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    rbmc_touch_s touch;
    logic [7:0]  light = 8'h00;
    logic [7:0]  wake = 8'h28;
    logic [7:0]  forage = 8'h64;
    logic [7:0]  bright = 8'hC8;
    logic        beacon_rx = 1'b0;
    rbmc_motor_e motor;
    logic        sensors_on;
    logic        standby;
    logic        ir_tx_en;
    logic [7:0]  ir_tx_data;
    rbmc_led_s   led;
    int          failures = 0;
    int          comparisons = 0;
    integer      seed = 32'h12F52342;
    int          cycles = 0;
    int          s;
    int          r;
    int          c;
    int          len [4];
    logic [3:0]  sides [3] = '{4'h8, 4'h4, 4'hC};

    rbmc_ctrl #(.LW(8)) u_rbmc_ctrl (.sys_clk(sys_clk), .reset(reset), .touch_in(touch),
        .light_level(light), .wake_level(wake), .forage_level(forage),
        .bright_level(bright), .beacon_rx(beacon_rx), .motor_cmd(motor),
        .sensors_on(sensors_on), .standby(standby), .ir_tx_en(ir_tx_en),
        .ir_tx_data(ir_tx_data), .led(led));
    rbmc_world u_rbmc_world (.sys_clk(sys_clk), .touch(touch));

    // Free-running system clock.
    always #4 sys_clk = ~sys_clk;

    // Cuts a hung run short.
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            summarize();
        end
    end

    task automatic summarize();
        if (failures == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    // Waits whole cycles and samples just after the edge, where inputs also change.
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    function automatic logic [7:0] rnd(input int m);
        return 8'($unsigned($random(seed)) % m);
    endfunction

    // Expected turn: away from a single feeler.
    function automatic rbmc_motor_e away(input logic [3:0] f);
        return f[3] ? RBMC_MOT_RIGHT : RBMC_MOT_LEFT;
    endfunction

    task automatic wait_motor(input rbmc_motor_e m, input int lim);
        for (int i = 0; i < lim && motor !== m; i++)
            tick(1);
        check(32'(motor), 32'(m), "motor wait");
    endtask

    task automatic run_len(input rbmc_motor_e m, output int n);
        n = 0;
        while (motor === m && n < 300)
        begin
            tick(1);
            n++;
        end
    endtask

    task automatic wait_sb(input logic v);
        for (int i = 0; i < 30 && standby !== v; i++)
            tick(1);
        check(32'(standby), 32'(v), "standby level");
    endtask

    task automatic watch(input int k, output int stops, output int reds);
        stops = 0;
        reds = 0;
        repeat (k)
        begin
            tick(1);
            stops += int'(motor === RBMC_MOT_STOP);
            reds += int'(led.red === 1'b1);
        end
    endtask

    // Presses feelers while moving and measures the avoidance manoeuvre.
    task automatic avoid(input logic [3:0] f);
        int          n;
        rbmc_motor_e t;
        wait_motor(RBMC_MOT_FWD, 400);
        fork
            u_rbmc_world.press(f, 20 + int'(rnd(10)));
        join_none
        wait_motor(RBMC_MOT_REV, 60);
        run_len(RBMC_MOT_REV, n);
        check(32'(n), 32'(BACKUP_CYC), "reverse length");
        t = motor;
        if (f == 4'hC)
            check(32'(t == RBMC_MOT_LEFT || t == RBMC_MOT_RIGHT), 1, "both turn");
        else
            check(32'(t), 32'(away(f)), "turn side");
        run_len(t, n);
        check(32'(n >= TURN45_CYC), 1, "turn length");
        check(32'(motor !== RBMC_MOT_STOP), 1, "behaviour resumes");
        for (n = 0; n < 60 && motor !== RBMC_MOT_REV; n++)
            tick(1);
        check(32'(n), 60, "single contact event");
    endtask

    // Main sequence through sleep, walk, avoidance, halt, beacon, low light and power off.
    initial
    begin
        tick(4);
        reset = 1'b0;
        light = 8'h14 + rnd(20);
        tick(60);
        check(32'(standby), 1, "asleep");
        check(32'(motor), 32'(RBMC_MOT_STOP), "asleep motor");
        check(32'(led), 32'h3, "sleep colour");
        light = wake;
        wait_sb(1'b0);
        check(32'(sensors_on), 1, "awake sensors");
        light = 8'h78 + rnd(80);
        watch(200, s, r);
        check(32'(r), 0, "active colour");
        for (int i = 0; i < 4; i++)
        begin
            wait_motor(RBMC_MOT_FWD, 400);
            run_len(RBMC_MOT_FWD, len[i]);
        end
        check(32'(len[0] == len[1] && len[1] == len[2] && len[2] == len[3]), 0, "walk");
        for (int i = 0; i < 3; i++)
            avoid(sides[i]);
        u_rbmc_world.press(4'h2, 20);
        tick(2);
        check(32'(sensors_on), 1, "hibernate powered");
        check(32'(led.green), 0, "hibernate colour");
        watch(200, s, r);
        check(32'(s), 200, "hibernate still");
        check(32'(r > 0 && r < 200), 1, "hibernate pulsed");
        u_rbmc_world.press(4'h2, 20);
        watch(100, s, r);
        check(32'(s < 100 && r == 0), 1, "behaviour back");
        light = 8'h30 + rnd(16);
        tick(20);
        light = bright + rnd(40);
        for (int i = 0; i < 30 && ir_tx_en !== 1'b1; i++)
            tick(1);
        check(32'(ir_tx_en), 1, "beacon on");
        check(32'(ir_tx_data), 32'(light), "beacon data");
        check(32'(motor), 32'(RBMC_MOT_STOP), "beacon still");
        light = 8'h30;
        for (c = 0; c < 300 && ir_tx_en === 1'b1; c++)
            tick(1);
        check(32'(c >= BEACON_CYC - 1 && c <= BEACON_CYC + 1), 1, "beacon period");
        beacon_rx = 1'b1;
        watch(100, s, r);
        beacon_rx = 1'b0;
        check(32'(s < 100), 1, "converge moves");
        light = rnd(20);
        wait_sb(1'b1);
        check(32'(sensors_on), 0, "low power sensors");
        check(32'(motor), 32'(RBMC_MOT_STOP), "low power motor");
        light = 8'hA0;
        wait_sb(1'b0);
        u_rbmc_world.press(4'h1, 20);
        tick(2);
        check(32'(led), 0, "off dark");
        light = 8'hFF;
        watch(300, s, r);
        check(32'(s), 300, "hard off stays");
        check(32'(standby && !sensors_on), 1, "hard off power");
        summarize();
    end
endmodule
